// ==== logic/gpp_port.sv ====
// Notes on behaviour
// (R1) Reset: pins are software inputs; test-port pins come up alternate-selected.
// (R2) Any reset restores direction and alternate-select defaults for all pins.
// (R3) Direction 0: pin is input; data bit captures the pin level.
// (R4) Direction 1: data register bit drives the pin.
// (R5) Data window spans 256 words; address bits 9..2 form the pin mask.
// (R6) Writes update only data bits whose address mask bit is one.
// (R7) Reads return zero for bits whose address mask bit is zero.
// (R8) Reads give written value for outputs, pin level for inputs; reset clears.
// (R9) All pin interrupts combine into one port interrupt output.
// (R10) Rising, falling, both-edge and high or low level detection are offered.
// (R11) Sense: edge 0/level 1; dual: single/both; polarity: low/falling 0.
// (R12) Edge interrupt stays latched until cleared by software.
// (R13) Level sources must hold the level until the interrupt is recognised.
// (R14) Per-pin mask gates forwarding to the port interrupt.
// (R15) Mask 0 blocks, 1 passes; mask resets to zero.
// (R16) Raw status shows met conditions regardless of mask.
// (R17) Masked status shows conditions both present and enabled.
// (R18) Writing 1 to clear location clears that latch; 0 does nothing.
// (R19) Port B pin four unmasked also pulses the converter trigger.
// (R20) Software should mask pins before changing sense settings.
// (R21) Sense setting writes may cause spurious interrupts; not suppressed.
// (R22) All five ports are identical instances of this block.
// (R23) Alternate select 1 hands the pin to its peripheral; 0 software.
// (R24) Pins are synchronised; edges compare successive synchronised samples.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module gpp_port #(
    parameter int         WIDTH   = 8,
    parameter logic [7:0] ALT_RST = gpp_pkg::RST_ZERO,
    parameter bit         HAS_TRIG = 1'b0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe,
    input  wire logic [WIDTH-1:0] alt_out,
    input  wire logic [WIDTH-1:0] alt_oe,
    output logic      [WIDTH-1:0] alt_in,
    output logic                  port_irq,
    output logic                  conv_trigger
);

    typedef struct packed {
        gpp_pkg::gpp_cfg_t cfg;
        logic [WIDTH-1:0]  data;
        logic [31:0]       rdata;
        logic              ready;
        logic              err;
        logic [WIDTH-1:0]  pout;
        logic [WIDTH-1:0]  poe;
        logic [WIDTH-1:0]  ain;
        logic              irq;
        logic              trig;
        logic              trig_prev;
    } gpp_state_t;

    gpp_state_t       st_r;
    gpp_state_t       st_nxt;
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] clear;
    logic             acc;
    logic             wr;
    logic             in_window;
    logic [WIDTH-1:0] amask;
    logic [WIDTH-1:0] wbyte;
    logic [WIDTH-1:0] masked;
    logic [WIDTH-1:0] data_view;

    // Access decode; the slave answers one cycle after the first access cycle (one wait state).
    assign acc       = psel & penable & ~st_r.ready;
    assign wr        = acc & pwrite;
    assign in_window = (paddr <= gpp_pkg::OFF_DATA_HI);      // [R5]
    assign amask     = paddr[gpp_pkg::MASK_MSB:gpp_pkg::MASK_LSB]; // [R5]
    assign wbyte     = pwdata[WIDTH-1:0];
    assign clear     = (wr && paddr == gpp_pkg::OFF_CLEAR) ? wbyte : '0; // [R18]
    assign masked    = raw & st_r.cfg.mask;                  // [R14] [R15] [R17]

    // Output pins read back the written bit, input pins the synchronised level.
    assign data_view = (st_r.data & st_r.cfg.dir) | (pin_sync & ~st_r.cfg.dir); // [R3] [R8]

    // Interrupt detection with synchroniser and sticky edge latches.
    gpp_irq_detect #(
        .WIDTH (WIDTH)
    ) u_detect (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (pin_in),
        .sense     (st_r.cfg.sense),
        .dual      (st_r.cfg.dual),
        .polarity  (st_r.cfg.polarity),
        .clear     (clear),
        .pin_sync  (pin_sync),
        .raw       (raw)
    );

    // Next-state logic for registers, bus answer and pins.
    always_comb begin
        st_nxt       = st_r;
        st_nxt.ready = acc;
        st_nxt.err   = 1'b0;
        st_nxt.rdata = 32'h0000_0000;
        // Input pins keep the data register tracking their level.
        st_nxt.data  = (st_r.data & st_r.cfg.dir) | (pin_sync & ~st_r.cfg.dir); // [R3]
        if (wr) begin
            if (in_window) begin
                st_nxt.data = (st_nxt.data & ~(amask & st_r.cfg.dir))
                            | (wbyte & amask & st_r.cfg.dir);   // [R6]
            end else begin
                case (paddr)
                    gpp_pkg::OFF_DIR:      st_nxt.cfg.dir      = wbyte;
                    gpp_pkg::OFF_SENSE:    st_nxt.cfg.sense    = wbyte; // [R21]
                    gpp_pkg::OFF_DUAL:     st_nxt.cfg.dual     = wbyte; // [R21]
                    gpp_pkg::OFF_POLARITY: st_nxt.cfg.polarity = wbyte; // [R21]
                    gpp_pkg::OFF_MASK:     st_nxt.cfg.mask     = wbyte; // [R14]
                    gpp_pkg::OFF_ALTSEL:   st_nxt.cfg.altsel   = wbyte; // [R23]
                    gpp_pkg::OFF_CLEAR:    st_nxt.err          = 1'b0;
                    default:               st_nxt.err          = acc;
                endcase
            end
        end else if (acc) begin
            if (in_window) begin
                st_nxt.rdata[WIDTH-1:0] = data_view & amask;    // [R7] [R8]
            end else begin
                case (paddr)
                    gpp_pkg::OFF_DIR:      st_nxt.rdata[WIDTH-1:0] = st_r.cfg.dir;
                    gpp_pkg::OFF_SENSE:    st_nxt.rdata[WIDTH-1:0] = st_r.cfg.sense;
                    gpp_pkg::OFF_DUAL:     st_nxt.rdata[WIDTH-1:0] = st_r.cfg.dual;
                    gpp_pkg::OFF_POLARITY: st_nxt.rdata[WIDTH-1:0] = st_r.cfg.polarity;
                    gpp_pkg::OFF_MASK:     st_nxt.rdata[WIDTH-1:0] = st_r.cfg.mask;
                    gpp_pkg::OFF_RAW:      st_nxt.rdata[WIDTH-1:0] = raw;    // [R16]
                    gpp_pkg::OFF_MASKED:   st_nxt.rdata[WIDTH-1:0] = masked; // [R17]
                    gpp_pkg::OFF_ALTSEL:   st_nxt.rdata[WIDTH-1:0] = st_r.cfg.altsel;
                    gpp_pkg::OFF_CLEAR:    st_nxt.rdata            = 32'h0000_0000;
                    default:               st_nxt.err              = 1'b1;
                endcase
            end
        end
        // Pad drive: peripheral when alternate-selected, otherwise data and direction.
        st_nxt.pout = (alt_out & st_r.cfg.altsel) | (st_r.data & ~st_r.cfg.altsel); // [R4] [R23]
        st_nxt.poe  = (alt_oe & st_r.cfg.altsel) | (st_r.cfg.dir & ~st_r.cfg.altsel); // [R4] [R23]
        st_nxt.ain  = pin_sync;
        st_nxt.irq  = |masked;                                  // [R9]
        // Trigger is a one-cycle pulse on each new unmasked pin-four condition.
        st_nxt.trig_prev = masked[gpp_pkg::TRIG_PIN];
        st_nxt.trig = HAS_TRIG & masked[gpp_pkg::TRIG_PIN] & ~st_r.trig_prev; // [R19]
    end

    // State register; both reset sources arrive merged on presetn.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r            <= '0;                          // [R1] [R8] [R15]
            st_r.cfg.altsel <= ALT_RST;                     // [R1] [R2]
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register.
    assign prdata       = st_r.rdata;
    assign pready       = st_r.ready;
    assign pslverr      = st_r.err;
    assign pin_out      = st_r.pout;
    assign pin_oe       = st_r.poe;
    assign alt_in       = st_r.ain;
    assign port_irq     = st_r.irq;                         // [R9] [R22]
    assign conv_trigger = st_r.trig;

endmodule : gpp_port

`default_nettype wire

// ==== logic/gpp_pkg.sv ====
`default_nettype none

package gpp_pkg;

    // Register byte offsets inside one port's 4 KB window.
    localparam logic [11:0] OFF_DATA_LO   = 12'h000;
    localparam logic [11:0] OFF_DATA_HI   = 12'h3fc;
    localparam logic [11:0] OFF_DIR       = 12'h400;
    localparam logic [11:0] OFF_SENSE     = 12'h404;
    localparam logic [11:0] OFF_DUAL      = 12'h408;
    localparam logic [11:0] OFF_POLARITY  = 12'h40c;
    localparam logic [11:0] OFF_MASK      = 12'h410;
    localparam logic [11:0] OFF_RAW       = 12'h414;
    localparam logic [11:0] OFF_MASKED    = 12'h418;
    localparam logic [11:0] OFF_CLEAR     = 12'h41c;
    localparam logic [11:0] OFF_ALTSEL    = 12'h420;

    // Data window mask field position in the byte address.
    localparam int          MASK_LSB      = 2;
    localparam int          MASK_MSB      = 9;

    // Reset values.
    localparam logic [7:0]  RST_ZERO      = 8'h00;
    localparam logic [7:0]  RST_ALT_PORTB = 8'h80;
    localparam logic [7:0]  RST_ALT_PORTC = 8'h0f;

    // Trigger source pin within port B.
    localparam int          TRIG_PIN      = 4;

    // Configuration registers of one port.
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] sense;
        logic [7:0] dual;
        logic [7:0] polarity;
        logic [7:0] mask;
        logic [7:0] altsel;
    } gpp_cfg_t;

    // Pin-side group towards the pads.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } gpp_pad_t;

endpackage : gpp_pkg

`default_nettype wire

// ==== logic/gpp_irq_detect.sv ====
`timescale 1ns/1ps
`default_nettype none

module gpp_irq_detect #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin_async,
    input  wire logic [WIDTH-1:0] sense,
    input  wire logic [WIDTH-1:0] dual,
    input  wire logic [WIDTH-1:0] polarity,
    input  wire logic [WIDTH-1:0] clear,
    output logic      [WIDTH-1:0] pin_sync,
    output logic      [WIDTH-1:0] raw
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lat;
    } gpp_det_t;

    gpp_det_t st_r;
    gpp_det_t st_nxt;
    logic [WIDTH-1:0] level_hit;

    // Per pin: three-stage synchroniser, edge detect, sticky latch.
    always_comb begin
        st_nxt    = st_r;
        level_hit = '0;
        st_nxt.s1 = pin_async;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < WIDTH; i++) begin
            logic rise;
            logic fall;
            logic edge_hit;
            rise     = st_r.s2[i] & ~st_r.s3[i];              // [R24]
            fall     = ~st_r.s2[i] & st_r.s3[i];              // [R24]
            edge_hit = dual[i] ? (rise | fall) : (polarity[i] ? rise : fall); // [R10] [R11]
            level_hit[i] = sense[i] & (st_r.s3[i] == polarity[i]); // [R10] [R11]
            // Set wins over a clear in the same cycle; level mode keeps no latch.
            if (sense[i]) begin
                st_nxt.lat[i] = 1'b0;
            end else if (edge_hit) begin
                st_nxt.lat[i] = 1'b1;                         // [R12]
            end else if (clear[i]) begin
                st_nxt.lat[i] = 1'b0;                         // [R18]
            end
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // The synchronised level is stage three, taken every cycle with no match check.
    assign pin_sync = st_r.s3;
    assign raw      = st_r.lat | level_hit;                  // [R16]

endmodule : gpp_irq_detect

`default_nettype wire

// ==== test/gpp_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Pads of one port: a driven pin shows the port's value, any other the outside source.
module gpp_pin_model (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_lvl,
    output logic      [7:0] pin_in
);
    // The outside source holds each level steady until the bench changes it.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // gpp_pin_model

`default_nettype wire

// ==== test/gpp_port_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module gpp_port_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  pin_oe,
    input wire logic        port_irq,
    input wire logic        conv_trigger
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answers, read masking, reset state and interrupt outputs.
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("no answer after one wait");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("answer held too long");
    property p_mask_rd;
        pready && !pwrite && paddr[11:10] == 2'b00 |-> (prdata[7:0] & ~paddr[9:2]) == 8'h00;
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("masked bit read nonzero");
    property p_hi_zero; pready |-> prdata[31:8] == 24'h000000; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
    property p_win_ok; pready && paddr[11:10] == 2'b00 |-> !pslverr; endproperty
    a_win_ok: assert property (p_win_ok) else $error("data window refused");
    property p_rst_in; $rose(presetn) |-> pin_oe == 8'h00; endproperty
    a_rst_in: assert property (p_rst_in) else $error("pin driven at reset");
    property p_trig_pulse; conv_trigger |=> !conv_trigger; endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
    property p_trig_irq; conv_trigger |-> port_irq; endproperty
    a_trig_irq: assert property (p_trig_irq) else $error("trigger without irq");
    property p_mask_off;
        pready && pwrite && paddr == gpp_pkg::OFF_MASK && pwdata[7:0] == 8'h00
            |-> ##[1:3] !port_irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq not masked");

    // Main scenarios reached.
    c_trig: cover property (conv_trigger);
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(port_irq));
endmodule // gpp_port_checker

bind gpp_port gpp_port_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_oe, .port_irq, .conv_trigger);

`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, port_irq, conv_trigger, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [7:0]  pin_in, pin_out, pin_oe, alt_in, ext_lvl = 8'h00;
    int          bad_count = 0, samples_checked = 0, trig_n = 0;
    // Rows: address mask, write data, expected data register.
    // Bit 7 was captured high from the peripheral-driven pin while still an input.
    logic [7:0]  rows [4][3] = '{'{8'h26, 8'heb, 8'ha2}, '{8'hff, 8'h5a, 8'h5a},
                                 '{8'h0f, 8'hff, 8'h5f}, '{8'h00, 8'hff, 8'h5f}};

    gpp_port #(.ALT_RST(gpp_pkg::RST_ALT_PORTB), .HAS_TRIG(1'b1)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pin_in, .pin_out, .pin_oe, .alt_out(8'h80), .alt_oe(8'h80), .alt_in,
        .port_irq, .conv_trigger);
    gpp_pin_model u_pins (.pin_out, .pin_oe, .ext_lvl, .pin_in);

    // Clock and trigger pulse counter.
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) if (conv_trigger === 1'b1) trig_n++;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; holds the request until pready is seen high.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, rv, exp);
    endtask

    task automatic rst_chk();
        rd_chk("dir", gpp_pkg::OFF_DIR, 32'h0);
        rd_chk("altsel", gpp_pkg::OFF_ALTSEL, 32'h80);
        rd_chk("mask", gpp_pkg::OFF_MASK, 32'h0);
        rd_chk("sense", gpp_pkg::OFF_SENSE, 32'h0);
        chk("oe", 32'(pin_oe), 32'h80);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rst_chk();
        bus(1'b1, gpp_pkg::OFF_DIR, 32'hff);
        foreach (rows[i]) begin
            bus(1'b1, {2'b00, rows[i][0], 2'b00}, 32'(rows[i][1]));
            rd_chk("data", gpp_pkg::OFF_DATA_HI, 32'(rows[i][2]));
            rd_chk("data 0c4", 12'h0c4, 32'(rows[i][2] & 8'h31));
            chk("pin_out", 32'(pin_out), 32'({1'b1, rows[i][2][6:0]}));
        end
        bus(1'b1, gpp_pkg::OFF_DIR, 32'h0);
        ext_lvl <= 8'h25;
        repeat (6) @(posedge pclk);
        rd_chk("pins in", gpp_pkg::OFF_DATA_HI, 32'ha5);
        chk("alt_in", 32'(alt_in), 32'ha5);
        // Interrupts stay masked while their sensing is set up.
        ext_lvl <= 8'h04;
        bus(1'b1, gpp_pkg::OFF_MASK, 32'h0);
        bus(1'b1, gpp_pkg::OFF_SENSE, 32'h0c);
        bus(1'b1, gpp_pkg::OFF_DUAL, 32'h02);
        bus(1'b1, gpp_pkg::OFF_POLARITY, 32'h19);
        repeat (6) @(posedge pclk);
        bus(1'b1, gpp_pkg::OFF_CLEAR, 32'hff);
        rd_chk("raw idle", gpp_pkg::OFF_RAW, 32'h0);
        ext_lvl <= 8'h1b;
        repeat (6) @(posedge pclk);
        rd_chk("raw set", gpp_pkg::OFF_RAW, 32'h1f);
        rd_chk("masked none", gpp_pkg::OFF_MASKED, 32'h0);
        chk("irq off", 32'(port_irq), 32'h0);
        ext_lvl <= 8'h04;
        repeat (6) @(posedge pclk);
        bus(1'b1, gpp_pkg::OFF_CLEAR, 32'h00);
        rd_chk("raw held", gpp_pkg::OFF_RAW, 32'h13);
        bus(1'b1, gpp_pkg::OFF_CLEAR, 32'h01);
        rd_chk("raw clr", gpp_pkg::OFF_RAW, 32'h12);
        bus(1'b1, gpp_pkg::OFF_MASK, 32'h12);
        rd_chk("masked", gpp_pkg::OFF_MASKED, 32'h12);
        chk("irq on", 32'(port_irq), 32'h1);
        chk("trigger", 32'(trig_n), 32'h1);
        bus(1'b1, gpp_pkg::OFF_MASK, 32'h0);
        // The registered interrupt drops one edge after the mask register changes.
        @(posedge pclk);
        chk("irq masked", 32'(port_irq), 32'h0);
        rd_chk("bad addr", 12'h800, 32'h0);
        chk("err", 32'(err), 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rst_chk();
        end_of_test();
    end
endmodule // tb

`default_nettype wire
